// ===== bench/rstr_host_model.sv
// partner model: host side of the register strobe port
`timescale 1ns/1ps
module rstr_host_model (
   input  wire logic       clk,
   output      logic [7:0] regAddr,
   output      logic       regWrite,
   output      logic [7:0] regWdata,
   output      logic       regRead
);
   initial begin
      regAddr  = 8'h00;
      regWrite = 1'b0;
      regWdata = 8'h00;
      regRead  = 1'b0;
   end

   // request held through its sampling edge; released lines show a changed pattern
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regWdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      regAddr <= ~a;
   endtask
endmodule

// ===== bench/rstr_tuning_regs_checker.sv
// checker: port-level assertions for the tuning and test register bank
`timescale 1ns/1ps
module rstr_tuning_regs_checker (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] regAddr,
   input wire logic       regWrite,
   input wire logic [7:0] regWdata,
   input wire logic       regRead,
   input wire logic [7:0] regRdata_q,
   input wire logic [4:0] calPumpCode,
   input wire logic       pumpUpIn,
   input wire logic       pumpDownIn,
   input wire logic [3:0] rxMatchCode,
   input wire logic [3:0] txMatchCode,
   input wire logic       synthResetLow,
   input wire logic [1:0] preSwingCode,
   input wire logic [1:0] preCurrentCode,
   input wire logic       ifInputFromPin,
   input wire logic       ifFrontToPin,
   input wire logic       filterProbeOne,
   input wire logic       filterProbeTwo,
   input wire logic       pumpOutputGround,
   input wire logic [5:0] loopGainConstant,
   input wire logic       loopOpen,
   input wire logic [4:0] appliedPumpCode_q,
   input wire logic [3:0] appliedOscArrayCode_q,
   input wire logic [3:0] appliedCalCode_q,
   input wire logic       pumpUpOut_q,
   input wire logic       pumpDownOut_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_MATCH: assert property (regWrite && regAddr == 8'h12 |=> {rxMatchCode, txMatchCode} == $past(regWdata))
      else $error("matching codes differ from written byte");
   AST_SYNTH: assert property (regWrite && regAddr == 8'h13 |=> synthResetLow == $past(regWdata[0]))
      else $error("synth reset bit differs from written bit");
   AST_DIVIDER: assert property (regWrite && regAddr == 8'h1C |=> {preSwingCode, preCurrentCode, ifInputFromPin, ifFrontToPin} == $past(regWdata[7:2]))
      else $error("divider controls differ from written bits");
   AST_PROBE: assert property (regWrite && regAddr == 8'h40 |=> {filterProbeOne, filterProbeTwo} == $past(regWdata[7:6]) && pumpOutputGround == !(filterProbeOne || filterProbeTwo))
      else $error("probe routing or ground tie wrong");
   AST_PUMP_FORCE: assert property (regWrite && regAddr == 8'h40 && regWdata[5] ##1 !(regWrite && regAddr == 8'h40) |=> appliedPumpCode_q == $past(regWdata[4:0], 2))
      else $error("forced pump code not applied");
   AST_PUMP_CAL: assert property (regWrite && regAddr == 8'h40 && !regWdata[5] ##1 !(regWrite && regAddr == 8'h40) |=> appliedPumpCode_q == $past(calPumpCode))
      else $error("calibrated pump code not applied");
   AST_INHIBIT: assert property (regWrite && regAddr == 8'h41 && regWdata[5] ##1 !(regWrite && regAddr == 8'h41) |=> !pumpUpOut_q && !pumpDownOut_q)
      else $error("pump pulses pass while inhibited");
   AST_PULSE_SRC: assert property ((pumpUpOut_q |-> $past(pumpUpIn)) and (pumpDownOut_q |-> $past(pumpDownIn)))
      else $error("pump pulse without a raw pulse");
   AST_OSC_FORCE: assert property (regWrite && regAddr == 8'h41 && regWdata[4] ##1 !(regWrite && regAddr == 8'h41) |=> appliedOscArrayCode_q == $past(regWdata[3:0], 2))
      else $error("forced oscillator code not applied");
   AST_GAIN: assert property (regWrite && regAddr == 8'h42 |=> loopGainConstant == $past(regWdata[5:0]))
      else $error("loop gain constant differs from written bits");
   AST_BREAK: assert property (regWrite && regAddr == 8'h43 && regWdata[4] ##1 !(regWrite && regAddr == 8'h43) |=> loopOpen && appliedCalCode_q == $past(regWdata[3:0], 2))
      else $error("open loop does not apply forced cal code");
   AST_STATUS_READ: assert property (regRead && regAddr == 8'h44 |=> regRdata_q == {3'h0, $past(appliedPumpCode_q)})
      else $error("pump status readback wrong");
   AST_RESET: assert property ($rose(rst_n) |-> synthResetLow && loopGainConstant == 6'h25 && appliedPumpCode_q == 5'h10 && !loopOpen)
      else $error("reset values wrong after release");
endmodule

// ===== bench/tb.sv
// testbench: register bank scenarios driven through the host model, reads checked from a queue
`timescale 1ns/1ps
module tb;
   import rstr_pkg::*;
   logic        clk, rst_n, regWrite, regRead, pumpUpIn, pumpDownIn, rdSeen;
   logic [7:0]  regAddr, regWdata, regRdata_q;
   logic [4:0]  calPumpCode, appPump;
   logic [3:0]  calOscArrayCode, calDacCode, rxMatchCode, txMatchCode, appOsc, appCal;
   logic [1:0]  preSwingCode, preCurrentCode;
   logic [5:0]  loopGainConstant;
   logic        synthResetLow, ifInputFromPin, ifFrontToPin, probeOne, probeTwo;
   logic        pumpGnd, loopOpen, upOut, downOut;
   logic [15:0] expQ[$];
   int          err_count, comparisons, cycles;

   rstr_tuning_regs dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead), .regRdata_q(regRdata_q),
      .calPumpCode(calPumpCode), .calOscArrayCode(calOscArrayCode), .calDacCode(calDacCode),
      .pumpUpIn(pumpUpIn), .pumpDownIn(pumpDownIn), .rxMatchCode(rxMatchCode),
      .txMatchCode(txMatchCode), .synthResetLow(synthResetLow), .preSwingCode(preSwingCode),
      .preCurrentCode(preCurrentCode), .ifInputFromPin(ifInputFromPin),
      .ifFrontToPin(ifFrontToPin), .filterProbeOne(probeOne), .filterProbeTwo(probeTwo),
      .pumpOutputGround(pumpGnd), .loopGainConstant(loopGainConstant), .loopOpen(loopOpen),
      .appliedPumpCode_q(appPump), .appliedOscArrayCode_q(appOsc), .appliedCalCode_q(appCal),
      .pumpUpOut_q(upOut), .pumpDownOut_q(downOut));
   rstr_host_model host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // observed value first, then the value the rules call for
   task automatic chk(string n, logic [7:0] g, logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report();
      $display("counts: comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // read monitor: oldest note against the data loaded by the read
   // ------------------------------------------------------------
   always @(posedge clk) begin
      rdSeen <= regRead & rst_n;
      if (rdSeen && expQ.size() != 0) begin
         chk($sformatf("read %h", expQ[0][15:8]), regRdata_q, expQ[0][7:0]);
         void'(expQ.pop_front());
      end
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         final_report();
      end
   end

   task automatic rd_exp(logic [7:0] a, logic [7:0] e);
      expQ.push_back({a, e});
      host.rd(a);
   endtask

   task automatic wr_set(logic [7:0] a, logic [7:0] d);
      host.wr(a, d);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic rnd_in();
      logic [31:0] rv;
      rv = $urandom;
      @(posedge clk);
      calPumpCode     <= rv[4:0];
      calOscArrayCode <= rv[8:5];
      calDacCode      <= rv[12:9];
      repeat (2) @(posedge clk);
   endtask

   task automatic status_reads();
      rd_exp(8'h44, {3'h0, calPumpCode});
      rd_exp(8'h45, {4'h0, calDacCode});
      rd_exp(8'h46, {4'h0, calOscArrayCode});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   logic [7:0] adr[7]  = '{8'h12, 8'h13, 8'h1C, 8'h40, 8'h41, 8'h42, 8'h43};
   logic [7:0] rstv[7] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h08, 8'h25, 8'h04};
   logic [7:0] msk[7]  = '{8'hFF, 8'h01, 8'hFC, 8'hFF, 8'h3F, 8'h3F, 8'h1F};
   logic [7:0] d;

   initial begin
      rst_n = 1'b0;
      pumpUpIn = 1'b0;
      pumpDownIn = 1'b0;
      calPumpCode = 5'h03;
      calOscArrayCode = 4'h5;
      calDacCode = 4'h9;
      err_count = 0;
      comparisons = 0;
      void'($urandom(88699));
      do_reset();
      for (int i = 0; i < 7; i++) rd_exp(adr[i], rstv[i]);
      status_reads();
      rd_exp(8'h47, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 7; i++) begin
         d = 8'($urandom);
         host.wr(adr[i], d);
         rd_exp(adr[i], d & msk[i]);
      end
      host.wr(8'h40, 8'h2A);
      rd_exp(8'h44, 8'h0A);
      host.wr(8'h41, 8'h1B);
      rd_exp(8'h46, 8'h0B);
      wr_set(8'h43, 8'h13);
      chk("loopOpen", 8'(loopOpen), 8'h01);
      rd_exp(8'h45, 8'h03);
      host.wr(8'h40, 8'h00);
      host.wr(8'h41, 8'h00);
      wr_set(8'h43, 8'h03);
      chk("loopOpen", 8'(loopOpen), 8'h00);
      rnd_in();
      host.wr(8'h44, 8'hFF);
      host.wr(8'h60, 8'hFF);
      status_reads();
      rd_exp(8'h60, 8'h00);
      $display("test overrides and status done");
      wr_set(8'h12, 8'h17);
      chk("rxMatchCode", 8'(rxMatchCode), 8'h01);
      chk("txMatchCode", 8'(txMatchCode), 8'h07);
      for (int k = 0; k < 16; k++) begin
         d = {4'(k), ~2'(k), 2'h3};
         wr_set(8'h1C, d);
         chk("divider", 8'({preSwingCode, preCurrentCode, ifInputFromPin, ifFrontToPin}), 8'(d[7:2]));
      end
      for (int k = 0; k < 4; k++) begin
         wr_set(8'h40, {2'(k), 6'h00});
         chk("probes", 8'({probeOne, probeTwo, pumpGnd}), {5'h00, 2'(k), 1'(k == 0)});
      end
      wr_set(8'h13, 8'hFE);
      chk("synthResetLow", 8'(synthResetLow), 8'h00);
      wr_set(8'h42, 8'h3F);
      chk("loopGainConstant", 8'(loopGainConstant), 8'h3F);
      $display("test control fields done");
      for (int k = 1; k >= 0; k--) begin
         host.wr(8'h41, {2'h0, 1'(k), 5'h00});
         @(posedge clk);
         pumpUpIn <= 1'b1;
         pumpDownIn <= 1'b1;
         @(posedge clk);
         pumpUpIn <= 1'b0;
         pumpDownIn <= 1'b0;
         #1;
         chk("pump pulses", 8'({upOut, downOut}), (k == 1) ? 8'h00 : 8'h03);
      end
      $display("test pump pulses done");
      do_reset();
      rd_exp(8'h12, 8'h00);
      rd_exp(8'h13, 8'h01);
      rd_exp(8'h42, 8'h25);
      repeat (3) @(posedge clk);
      chk("notes left", 8'(expQ.size()), 8'h00);
      $display("test second reset done");
      final_report();
   end
endmodule

bind rstr_tuning_regs rstr_tuning_regs_checker u_chk (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
   .regRdata_q(regRdata_q), .calPumpCode(calPumpCode), .pumpUpIn(pumpUpIn),
   .pumpDownIn(pumpDownIn), .rxMatchCode(rxMatchCode), .txMatchCode(txMatchCode),
   .synthResetLow(synthResetLow), .preSwingCode(preSwingCode),
   .preCurrentCode(preCurrentCode), .ifInputFromPin(ifInputFromPin),
   .ifFrontToPin(ifFrontToPin), .filterProbeOne(filterProbeOne),
   .filterProbeTwo(filterProbeTwo), .pumpOutputGround(pumpOutputGround),
   .loopGainConstant(loopGainConstant), .loopOpen(loopOpen),
   .appliedPumpCode_q(appliedPumpCode_q), .appliedOscArrayCode_q(appliedOscArrayCode_q),
   .appliedCalCode_q(appliedCalCode_q), .pumpUpOut_q(pumpUpOut_q),
   .pumpDownOut_q(pumpDownOut_q));

// ===== verilog/rstr_field_reg.sv
// module: one writable register, storing a slice of the written byte
`timescale 1ns/1ps
module rstr_field_reg #(
   parameter logic [7:0]       ADDR  = 8'h00,
   parameter int               LSB   = 0,
   parameter int               WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   rstr_wr_if.sink               wr,
   output      logic [WIDTH-1:0] field_q
);

   // bits outside the slice are never stored, so writes to them vanish
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         field_q <= RESET;
      end else if (wr.wrEn && (wr.addr == ADDR)) begin
         field_q <= wr.wdata[LSB+WIDTH-1:LSB];
      end
   end

endmodule

// ===== verilog/rstr_pkg.sv
// package: register map, field layout and reset values of the tuning and test register bank
package rstr_pkg;

   // ------------------------------------------------------------
   // register bus geometry
   // ------------------------------------------------------------
   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 8;
   localparam logic [7:0]  READ_ZERO = 8'h00;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_ANTENNA_TUNING_CAPS       = 8'h12;
   localparam logic [7:0]  ADDR_SYNTH_CONTROL             = 8'h13;
   localparam logic [7:0]  ADDR_DIVIDER_DRIVE_SETUP       = 8'h1C;
   localparam logic [7:0]  ADDR_PUMP_CURRENT_OVERRIDE     = 8'h40;
   localparam logic [7:0]  ADDR_OSCILLATOR_ARRAY_OVERRIDE = 8'h41;
   localparam logic [7:0]  ADDR_LOOP_BANDWIDTH_CONSTANT   = 8'h42;
   localparam logic [7:0]  ADDR_LOOP_BREAK_CONTROL        = 8'h43;
   localparam logic [7:0]  ADDR_APPLIED_PUMP_CURRENT      = 8'h44;
   localparam logic [7:0]  ADDR_APPLIED_CAL_CODE          = 8'h45;
   localparam logic [7:0]  ADDR_APPLIED_OSC_ARRAY         = 8'h46;

   // ------------------------------------------------------------
   // storage of each writable register: lowest stored bit, width, reset
   // ------------------------------------------------------------
   localparam int          MATCH_LSB   = 0;
   localparam int          MATCH_W     = 8;
   localparam logic [7:0]  MATCH_RST   = 8'h00;
   localparam int          SYNTH_LSB   = 0;
   localparam int          SYNTH_W     = 1;
   localparam logic [0:0]  SYNTH_RST   = 1'h1;
   localparam int          DIVDRV_LSB  = 2;
   localparam int          DIVDRV_W    = 6;
   localparam logic [5:0]  DIVDRV_RST  = 6'h00;
   localparam int          PUMP_LSB    = 0;
   localparam int          PUMP_W      = 8;
   localparam logic [7:0]  PUMP_RST    = 8'h10;
   localparam int          OSC_LSB     = 0;
   localparam int          OSC_W       = 6;
   localparam logic [5:0]  OSC_RST     = 6'h08;
   localparam int          LOOPBW_LSB  = 0;
   localparam int          LOOPBW_W    = 6;
   localparam logic [5:0]  LOOPBW_RST  = 6'h25;
   localparam int          BREAK_LSB   = 0;
   localparam int          BREAK_W     = 5;
   localparam logic [4:0]  BREAK_RST   = 5'h04;

   // ------------------------------------------------------------
   // field positions inside the stored values
   // ------------------------------------------------------------
   localparam int RX_MATCH_HI   = 7;
   localparam int RX_MATCH_LO   = 4;
   localparam int TX_MATCH_HI   = 3;
   localparam int TX_MATCH_LO   = 0;
   localparam int SWING_HI      = 5;   // register bits 7:6
   localparam int SWING_LO      = 4;
   localparam int CURRENT_HI    = 3;   // register bits 5:4
   localparam int CURRENT_LO    = 2;
   localparam int IF_INPUT_BIT  = 1;   // register bit 3
   localparam int IF_FRONT_BIT  = 0;   // register bit 2
   localparam int PROBE_ONE_BIT = 7;
   localparam int PROBE_TWO_BIT = 6;
   localparam int PUMP_FORCE_BIT = 5;
   localparam int PUMP_CODE_HI  = 4;
   localparam int PUMP_CODE_LO  = 0;
   localparam int INHIBIT_BIT   = 5;
   localparam int OSC_FORCE_BIT = 4;
   localparam int OSC_CODE_HI   = 3;
   localparam int OSC_CODE_LO   = 0;
   localparam int BREAK_BIT     = 4;
   localparam int CAL_CODE_HI   = 3;
   localparam int CAL_CODE_LO   = 0;

   localparam int PUMP_CODE_W   = 5;
   localparam int OSC_CODE_W    = 4;
   localparam int CAL_CODE_W    = 4;

endpackage

// ===== verilog/rstr_tuning_regs.sv
// module: synthesizer tuning, divider drive and pll test register bank
`timescale 1ns/1ps
// Operation
// [RL1] upper nibble of matching register drives receive capacitor code, 0.4 pF steps
// [RL2] lower nibble drives transmit capacitor code; both nibbles reset to zero
// [RL3] synth control bit 0 is an active-low synthesizer reset, resets to 1
// [RL4] divider drive bits 7:6 select prescaler swing fraction
// [RL5] divider drive bits 5:4 select prescaler current fraction, reset 00
// [RL6] bit 3 set makes the signal strength pin the IF strip input
// [RL7] bit 2 set routes IF front amplifier output to signal strength pin
// [RL8] pump register bits 7 and 6 route filter probes; clear ties node to ground
// [RL9] pump force bit applies forced 5-bit current code, reset 10000
// [RL10] pulse inhibit bit suppresses charge pump up and down pulses
// [RL11] oscillator force bit applies forced 4-bit array code, reset 1000
// [RL12] 6-bit loop gain constant sets PLL bandwidth, resets to 100101
// [RL13] loop break opens the loop and applies forced cal code, reset 0100
// [RL14] read-only field shows the applied charge pump current code
// [RL15] read-only field shows the applied calibration DAC code
// [RL16] read-only field shows the applied oscillator array code
// [RL17] unused bits read zero, ignore writes; status registers ignore writes
module rstr_tuning_regs (
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   // register port
   input  wire logic [rstr_pkg::ADDR_W-1:0]     regAddr,
   input  wire logic                            regWrite,
   input  wire logic [rstr_pkg::DATA_W-1:0]     regWdata,
   input  wire logic                            regRead,
   output      logic [rstr_pkg::DATA_W-1:0]     regRdata_q,
   // calibrated values and pulses from the synthesizer
   input  wire logic [rstr_pkg::PUMP_CODE_W-1:0] calPumpCode,
   input  wire logic [rstr_pkg::OSC_CODE_W-1:0]  calOscArrayCode,
   input  wire logic [rstr_pkg::CAL_CODE_W-1:0]  calDacCode,
   input  wire logic                            pumpUpIn,
   input  wire logic                            pumpDownIn,
   // analogue controls
   output      logic [3:0]                      rxMatchCode,
   output      logic [3:0]                      txMatchCode,
   output      logic                            synthResetLow,
   output      logic [1:0]                      preSwingCode,
   output      logic [1:0]                      preCurrentCode,
   output      logic                            ifInputFromPin,
   output      logic                            ifFrontToPin,
   output      logic                            filterProbeOne,
   output      logic                            filterProbeTwo,
   output      logic                            pumpOutputGround,
   output      logic [5:0]                      loopGainConstant,
   output      logic                            loopOpen,
   output      logic [rstr_pkg::PUMP_CODE_W-1:0] appliedPumpCode_q,
   output      logic [rstr_pkg::OSC_CODE_W-1:0]  appliedOscArrayCode_q,
   output      logic [rstr_pkg::CAL_CODE_W-1:0]  appliedCalCode_q,
   output      logic                            pumpUpOut_q,
   output      logic                            pumpDownOut_q
);
   import rstr_pkg::*;

   // ------------------------------------------------------------
   // write port fan-out
   // ------------------------------------------------------------
   rstr_wr_if wrBus ();

   // only writable offsets reach storage; the status offsets have no store
   assign wrBus.wrEn  = regWrite;  // [RL17]
   assign wrBus.addr  = regAddr;
   assign wrBus.wdata = regWdata;

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [MATCH_W-1:0]  matchQ;
   logic [SYNTH_W-1:0]  synthQ;
   logic [DIVDRV_W-1:0] divDrvQ;
   logic [PUMP_W-1:0]   pumpQ;
   logic [OSC_W-1:0]    oscQ;
   logic [LOOPBW_W-1:0] loopBwQ;
   logic [BREAK_W-1:0]  breakQ;

   rstr_field_reg #(
      .ADDR  (ADDR_ANTENNA_TUNING_CAPS),
      .LSB   (MATCH_LSB),
      .WIDTH (MATCH_W),
      .RESET (MATCH_RST)
   ) uMatch (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (matchQ)
   );

   // only bit 0 is stored; the reserved and unused bits read zero
   rstr_field_reg #(
      .ADDR  (ADDR_SYNTH_CONTROL),
      .LSB   (SYNTH_LSB),
      .WIDTH (SYNTH_W),
      .RESET (SYNTH_RST)
   ) uSynth (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (synthQ)
   );

   rstr_field_reg #(
      .ADDR  (ADDR_DIVIDER_DRIVE_SETUP),
      .LSB   (DIVDRV_LSB),
      .WIDTH (DIVDRV_W),
      .RESET (DIVDRV_RST)
   ) uDivDrv (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (divDrvQ)
   );

   rstr_field_reg #(
      .ADDR  (ADDR_PUMP_CURRENT_OVERRIDE),
      .LSB   (PUMP_LSB),
      .WIDTH (PUMP_W),
      .RESET (PUMP_RST)
   ) uPump (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (pumpQ)
   );

   rstr_field_reg #(
      .ADDR  (ADDR_OSCILLATOR_ARRAY_OVERRIDE),
      .LSB   (OSC_LSB),
      .WIDTH (OSC_W),
      .RESET (OSC_RST)
   ) uOsc (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (oscQ)
   );

   rstr_field_reg #(
      .ADDR  (ADDR_LOOP_BANDWIDTH_CONSTANT),
      .LSB   (LOOPBW_LSB),
      .WIDTH (LOOPBW_W),
      .RESET (LOOPBW_RST)
   ) uLoopBw (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (loopBwQ)
   );

   rstr_field_reg #(
      .ADDR  (ADDR_LOOP_BREAK_CONTROL),
      .LSB   (BREAK_LSB),
      .WIDTH (BREAK_W),
      .RESET (BREAK_RST)
   ) uBreak (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr      (wrBus.sink),
      .field_q (breakQ)
   );

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   logic                   pumpCurrentForce;
   logic [PUMP_CODE_W-1:0] pumpCurrentForcedCode;
   logic                   pumpPulseInhibit;
   logic                   oscArrayForce;
   logic [OSC_CODE_W-1:0]  oscArrayForcedCode;
   logic [CAL_CODE_W-1:0]  calForcedCode;

   assign rxMatchCode    = matchQ[RX_MATCH_HI:RX_MATCH_LO];     // [RL1]
   assign txMatchCode    = matchQ[TX_MATCH_HI:TX_MATCH_LO];     // [RL2]
   assign synthResetLow  = synthQ[0];                           // [RL3]
   // swing code 10 is passed on unchanged; its analogue meaning is not ours
   assign preSwingCode   = divDrvQ[SWING_HI:SWING_LO];          // [RL4]
   assign preCurrentCode = divDrvQ[CURRENT_HI:CURRENT_LO];      // [RL5]
   assign ifInputFromPin = divDrvQ[IF_INPUT_BIT];               // [RL6]
   assign ifFrontToPin   = divDrvQ[IF_FRONT_BIT];               // [RL7]

   assign filterProbeOne   = pumpQ[PROBE_ONE_BIT];              // [RL8]
   assign filterProbeTwo   = pumpQ[PROBE_TWO_BIT];              // [RL8]
   assign pumpOutputGround = ~(filterProbeOne | filterProbeTwo); // [RL8]

   assign pumpCurrentForce      = pumpQ[PUMP_FORCE_BIT];
   assign pumpCurrentForcedCode = pumpQ[PUMP_CODE_HI:PUMP_CODE_LO];
   assign pumpPulseInhibit      = oscQ[INHIBIT_BIT];
   assign oscArrayForce         = oscQ[OSC_FORCE_BIT];
   assign oscArrayForcedCode    = oscQ[OSC_CODE_HI:OSC_CODE_LO];

   assign loopGainConstant = loopBwQ;                           // [RL12]
   assign loopOpen         = breakQ[BREAK_BIT];                 // [RL13]
   assign calForcedCode    = breakQ[CAL_CODE_HI:CAL_CODE_LO];

   // ------------------------------------------------------------
   // applied codes
   // ------------------------------------------------------------
   // registered so the analogue side never sees a mux glitch
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         appliedPumpCode_q <= PUMP_RST[PUMP_CODE_HI:PUMP_CODE_LO];
      end else if (pumpCurrentForce) begin
         appliedPumpCode_q <= pumpCurrentForcedCode;            // [RL9]
      end else begin
         appliedPumpCode_q <= calPumpCode;                      // [RL9]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         appliedOscArrayCode_q <= OSC_RST[OSC_CODE_HI:OSC_CODE_LO];
      end else if (oscArrayForce) begin
         appliedOscArrayCode_q <= oscArrayForcedCode;           // [RL11]
      end else begin
         appliedOscArrayCode_q <= calOscArrayCode;              // [RL11]
      end
   end

   // forced code is ignored while the loop stays closed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         appliedCalCode_q <= BREAK_RST[CAL_CODE_HI:CAL_CODE_LO];
      end else if (loopOpen) begin
         appliedCalCode_q <= calForcedCode;                     // [RL13]
      end else begin
         appliedCalCode_q <= calDacCode;                        // [RL13]
      end
   end

   // ------------------------------------------------------------
   // charge pump pulse gating
   // ------------------------------------------------------------
   // one cycle of latency keeps up and down aligned with each other
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pumpUpOut_q   <= 1'b0;
         pumpDownOut_q <= 1'b0;
      end else begin
         pumpUpOut_q   <= pumpUpIn & ~pumpPulseInhibit;         // [RL10]
         pumpDownOut_q <= pumpDownIn & ~pumpPulseInhibit;       // [RL10]
      end
   end

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rdataD;

   always_comb begin
      if (regAddr == ADDR_ANTENNA_TUNING_CAPS) begin
         rdataD = matchQ;
      end else if (regAddr == ADDR_SYNTH_CONTROL) begin
         rdataD = {7'h00, synthQ};                              // [RL17]
      end else if (regAddr == ADDR_DIVIDER_DRIVE_SETUP) begin
         rdataD = {divDrvQ, 2'h0};                              // [RL17]
      end else if (regAddr == ADDR_PUMP_CURRENT_OVERRIDE) begin
         rdataD = pumpQ;
      end else if (regAddr == ADDR_OSCILLATOR_ARRAY_OVERRIDE) begin
         rdataD = {2'h0, oscQ};                                 // [RL17]
      end else if (regAddr == ADDR_LOOP_BANDWIDTH_CONSTANT) begin
         rdataD = {2'h0, loopBwQ};                              // [RL17]
      end else if (regAddr == ADDR_LOOP_BREAK_CONTROL) begin
         rdataD = {3'h0, breakQ};                               // [RL17]
      end else if (regAddr == ADDR_APPLIED_PUMP_CURRENT) begin
         rdataD = {3'h0, appliedPumpCode_q};                    // [RL14]
      end else if (regAddr == ADDR_APPLIED_CAL_CODE) begin
         rdataD = {4'h0, appliedCalCode_q};                     // [RL15]
      end else if (regAddr == ADDR_APPLIED_OSC_ARRAY) begin
         rdataD = {4'h0, appliedOscArrayCode_q};                // [RL16]
      end else begin
         rdataD = READ_ZERO;                                    // [RL17]
      end
   end

   // read data holds until the next read strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata_q <= READ_ZERO;
      end else if (regRead) begin
         regRdata_q <= rdataD;
      end
   end

endmodule

// ===== verilog/rstr_wr_if.sv
// interface: register write port shared by the bank and its field registers
`timescale 1ns/1ps
interface rstr_wr_if;
   logic       wrEn;
   logic [7:0] addr;
   logic [7:0] wdata;

   modport src  (output wrEn, output addr, output wdata);
   modport sink (input wrEn, input addr, input wdata);
endinterface
